/* File: hw/pbrgc_pkg.sv */
package pbrgc_pkg;
  // Register 1 field layout
  localparam int GAP_W = 6;
  localparam int GAP_LSB = 0;
  localparam int HOLDOFF_BIT = 6;
  localparam int REQ_BIT = 7;
  localparam int REG_W = 8;
  // Gap setting and holdoff values
  localparam logic [5:0] GAP_MAX = 6'h3f;
  localparam logic [5:0] GAP_RST = 6'h3f;
  localparam logic HOLDOFF_RST = 1'b0;
  // Consecutive resets that force the maximum gap
  localparam logic [1:0] RESETS_TO_MAX = 2'h2;
  // Reset and initialization phase lengths in clock cycles
  localparam int RST_LEN = 4;
  localparam int INIT_LEN = 8;
  // Controller command states
  typedef enum logic [1:0] {
    PBRGC_IDLE,
    PBRGC_READ,
    PBRGC_WRITE
  } pbrgc_state_e;
endpackage : pbrgc_pkg

/* File: hw/pbrgc_if.sv */
interface pbrgc_if;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic cfg_tx;
  logic bus_reset_busy;
  modport phy (
    input reg_wr,
    input reg_wdata,
    output reg_rdata,
    output cfg_tx,
    output bus_reset_busy
  );
  modport link (
    output reg_wr,
    output reg_wdata,
    input reg_rdata,
    input cfg_tx,
    input bus_reset_busy
  );
endinterface : pbrgc_if

/* File: hw/pbrgc_phy.sv */
// Contract
// RULE1 - Request bit write starts bus reset
// RULE2 - Request write also loads holdoff and gap
// RULE3 - Sent and received config packets load both
// RULE4 - Two unloaded resets force gap to 63
// RULE5 - Request-started reset keeps written gap
// RULE6 - Sent config values readable immediately
// RULE7 - Controller resets bus after sending config
// RULE8 - Confirming reset writes packet's values
// RULE9 - Other resets write gap 63, holdoff kept
// RULE10 - Register written only with request set
// RULE11 - Six-bit gap and reset counter kept
module pbrgc_phy #(
  parameter int RESET_CYCLES = pbrgc_pkg::RST_LEN
) (
  input wire logic mclk,
  input wire logic reset,
  // Link side
  pbrgc_if.phy lnk,
  // Packet side
  input wire logic cfg_send,
  input wire logic cfg_recv,
  input wire logic cfg_holdoff,
  input wire logic [5:0] cfg_gap,
  input wire logic ext_bus_reset,
  // Status
  output logic root_holdoff_flag,
  output logic [5:0] gap_setting,
  output logic bus_reset_active,
  output logic bus_reset_done
);
  // Reset, then initialization, then idle
  typedef enum logic [1:0] {
    PBRGC_SEQ_IDLE,
    PBRGC_SEQ_RESET,
    PBRGC_SEQ_INIT
  } pbrgc_seq_e;

  // Source of the next holdoff and gap
  typedef enum logic [1:0] {
    PBRGC_SRC_KEEP,
    PBRGC_SRC_REG,
    PBRGC_SRC_PKT,
    PBRGC_SRC_MAX
  } pbrgc_src_e;

  pbrgc_seq_e seq_q;
  pbrgc_seq_e seq_d;
  pbrgc_src_e src;
  logic req_wr;
  logic pkt_load;
  logic load;
  logic reset_start;
  logic reset_end;
  logic init_end;
  logic max_due;
  logic holdoff_d;
  logic [5:0] gap_d;
  logic [7:0] rst_cnt_q;
  logic [7:0] init_cnt_q;
  logic [1:0] unloaded_q;

  assign req_wr = lnk.reg_wr && lnk.reg_wdata[pbrgc_pkg::REQ_BIT];
  assign pkt_load = cfg_send || cfg_recv; // [RULE3]
  assign load = req_wr || pkt_load;
  // A reset may cut initialization short, but never restarts itself
  assign reset_start = (req_wr || ext_bus_reset) && seq_q != PBRGC_SEQ_RESET;
  assign reset_end = seq_q == PBRGC_SEQ_RESET && rst_cnt_q == 8'h01;
  assign init_end = seq_q == PBRGC_SEQ_INIT && init_cnt_q == 8'h01;
  assign max_due = reset_end && unloaded_q + 2'h1 >= pbrgc_pkg::RESETS_TO_MAX; // [RULE4]

  // Bus reset and initialization sequence
  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      PBRGC_SEQ_IDLE: begin
        if (reset_start) begin
          seq_d = PBRGC_SEQ_RESET; // [RULE1]
        end
      end
      PBRGC_SEQ_RESET: begin
        if (reset_end) begin
          seq_d = PBRGC_SEQ_INIT; // [RULE1]
        end
      end
      PBRGC_SEQ_INIT: begin
        if (reset_start) begin
          seq_d = PBRGC_SEQ_RESET; // [RULE1]
        end else if (init_end) begin
          seq_d = PBRGC_SEQ_IDLE;
        end
      end
      default: begin
        seq_d = PBRGC_SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      seq_q <= PBRGC_SEQ_IDLE;
    end else begin
      seq_q <= seq_d;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bus_reset_active <= 1'b0;
    end else begin
      bus_reset_active <= seq_d == PBRGC_SEQ_RESET;
    end
  end

  // Length of the reset phase
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rst_cnt_q <= 8'h00;
    end else if (reset_start) begin
      rst_cnt_q <= 8'(RESET_CYCLES);
    end else if (seq_q == PBRGC_SEQ_RESET) begin
      rst_cnt_q <= rst_cnt_q - 8'h01;
    end
  end

  // Length of the initialization phase
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      init_cnt_q <= 8'h00;
    end else if (reset_end) begin
      init_cnt_q <= 8'(pbrgc_pkg::INIT_LEN);
    end else if (seq_q == PBRGC_SEQ_INIT) begin
      init_cnt_q <= init_cnt_q - 8'h01;
    end
  end

  // Done only when initialization completes uncut
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bus_reset_done <= 1'b0;
    end else begin
      bus_reset_done <= init_end && !reset_start;
    end
  end

  // Consecutive reset count since last load
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      unloaded_q <= 2'h0;
    end else if (load) begin
      unloaded_q <= 2'h0; // [RULE11] [RULE5]
    end else if (reset_end && unloaded_q != pbrgc_pkg::RESETS_TO_MAX) begin
      unloaded_q <= unloaded_q + 2'h1; // [RULE11]
    end
  end

  // Register write first, then packets, then fallback
  always_comb begin
    src = PBRGC_SRC_KEEP;
    if (req_wr) begin
      src = PBRGC_SRC_REG; // [RULE2] [RULE5]
    end else if (pkt_load) begin
      src = PBRGC_SRC_PKT; // [RULE3]
    end else if (max_due) begin
      src = PBRGC_SRC_MAX; // [RULE4]
    end
  end

  always_comb begin
    holdoff_d = root_holdoff_flag;
    gap_d = gap_setting;
    case (src)
      PBRGC_SRC_REG: begin
        holdoff_d = lnk.reg_wdata[pbrgc_pkg::HOLDOFF_BIT]; // [RULE2]
        gap_d = lnk.reg_wdata[pbrgc_pkg::GAP_LSB +: pbrgc_pkg::GAP_W]; // [RULE2]
      end
      PBRGC_SRC_PKT: begin
        holdoff_d = cfg_holdoff; // [RULE3] [RULE6]
        gap_d = cfg_gap; // [RULE3]
      end
      PBRGC_SRC_MAX: begin
        gap_d = pbrgc_pkg::GAP_MAX; // [RULE4]
      end
      default: begin
        holdoff_d = root_holdoff_flag;
        gap_d = gap_setting;
      end
    endcase
  end

  // Holdoff flag
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      root_holdoff_flag <= pbrgc_pkg::HOLDOFF_RST;
    end else begin
      root_holdoff_flag <= holdoff_d;
    end
  end

  // Six-bit gap setting, 63 at most
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      gap_setting <= pbrgc_pkg::GAP_RST;
    end else begin
      gap_setting <= gap_d; // [RULE11]
    end
  end

  // Config transmit notice to the link
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lnk.cfg_tx <= 1'b0;
    end else begin
      lnk.cfg_tx <= cfg_send;
    end
  end

  assign lnk.reg_rdata = {1'b0, root_holdoff_flag, gap_setting}; // [RULE6]
  assign lnk.bus_reset_busy = bus_reset_active;
endmodule : pbrgc_phy

/* File: hw/pbrgc_link.sv */
module pbrgc_link (
  input wire logic mclk,
  input wire logic reset,
  // Link side
  pbrgc_if.link phy,
  // User commands
  input wire logic user_reset_req,
  output logic user_busy
);
  pbrgc_pkg::pbrgc_state_e state_q;
  logic confirm_q;
  logic pending_q;

  // Sent config packet arms a confirming reset
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      confirm_q <= 1'b0;
    end else if (phy.cfg_tx) begin
      confirm_q <= 1'b1; // [RULE7]
    end else if (state_q == pbrgc_pkg::PBRGC_WRITE) begin
      confirm_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pending_q <= 1'b0;
    end else if (user_reset_req) begin
      pending_q <= 1'b1;
    end else if (state_q == pbrgc_pkg::PBRGC_WRITE) begin
      pending_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= pbrgc_pkg::PBRGC_IDLE;
    end else begin
      case (state_q)
        pbrgc_pkg::PBRGC_IDLE: begin
          if ((confirm_q || pending_q) && !phy.bus_reset_busy && !phy.cfg_tx) begin
            state_q <= pbrgc_pkg::PBRGC_READ;
          end
        end
        pbrgc_pkg::PBRGC_READ: state_q <= pbrgc_pkg::PBRGC_WRITE;
        pbrgc_pkg::PBRGC_WRITE: state_q <= pbrgc_pkg::PBRGC_IDLE;
        default: state_q <= pbrgc_pkg::PBRGC_IDLE;
      endcase
    end
  end

  // Only writes with the request bit set
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      phy.reg_wr <= 1'b0;
      phy.reg_wdata <= 8'h00;
    end else if (state_q == pbrgc_pkg::PBRGC_READ) begin
      phy.reg_wr <= 1'b1; // [RULE10]
      if (confirm_q) begin
        phy.reg_wdata <= {1'b1, phy.reg_rdata[6:0]}; // [RULE8]
      end else begin
        phy.reg_wdata <= {1'b1, phy.reg_rdata[pbrgc_pkg::HOLDOFF_BIT], pbrgc_pkg::GAP_MAX}; // [RULE9]
      end
    end else begin
      phy.reg_wr <= 1'b0;
    end
  end

  assign user_busy = pending_q || confirm_q || state_q != pbrgc_pkg::PBRGC_IDLE;
endmodule : pbrgc_link

/* File: tb/pbrgc_sva.sv */
module pbrgc_sva (
  // Clock
  input wire logic mclk,
  input wire logic reset,
  // Bus
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic cfg_tx,
  input wire logic bus_reset_busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  req_rst_a: assert property (reg_wr && reg_wdata[7] && !bus_reset_busy |=> bus_reset_busy) else $error("rst");
  rst_len_a: assert property ($rose(bus_reset_busy) |-> bus_reset_busy[*4] ##1 !bus_reset_busy) else $error("len");
  wr_load_a: assert property (reg_wr && reg_wdata[7] |=> reg_rdata[6:0] == $past(reg_wdata[6:0])) else $error("ld");
  req_only_a: assert property (reg_wr |-> reg_wdata[7]) else $error("req");
  keep_hold_a: assert property (reg_wr |-> reg_wdata[6] == reg_rdata[6]) else $error("hold");
  gap_val_a: assert property (
    reg_wr |-> reg_wdata[5:0] == 6'h3f || reg_wdata[5:0] == reg_rdata[5:0]) else $error("gap");
  confirm_a: assert property (
    cfg_tx && !bus_reset_busy |-> ##[1:3] reg_wr && reg_wdata[6:0] == reg_rdata[6:0]) else $error("cfm");
  wr_keep_a: assert property (
    reg_wr && reg_wdata[7] && !bus_reset_busy |-> ##5 reg_rdata[5:0] == $past(reg_wdata[5:0], 5)) else $error("kept");
  rd_top_a: assert property (reg_rdata[7] == 1'b0) else $error("top");
endmodule : pbrgc_sva

/* File: tb/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic cfg_send = 1'b0, cfg_recv = 1'b0, cfg_holdoff = 1'b0, ext_bus_reset = 1'b0, user_reset_req = 1'b0;
  logic [5:0] cfg_gap = 6'h00, gap_setting;
  logic root_holdoff_flag, bus_reset_active, bus_reset_done, user_busy;
  int fail_count = 0, n_checks = 0, cyc = 0;
  pbrgc_if b ();
  pbrgc_phy pbrgc_phy_i (.mclk, .reset, .lnk(b), .cfg_send, .cfg_recv, .cfg_holdoff, .cfg_gap, .ext_bus_reset,
    .root_holdoff_flag, .gap_setting, .bus_reset_active, .bus_reset_done);
  pbrgc_link pbrgc_link_i (.mclk, .reset, .phy(b), .user_reset_req, .user_busy);
  pbrgc_sva pbrgc_sva_i (.mclk, .reset, .reg_wr(b.reg_wr), .reg_wdata(b.reg_wdata), .reg_rdata(b.reg_rdata),
    .cfg_tx(b.cfg_tx), .bus_reset_busy(b.bus_reset_busy));
  always #12.5 mclk = ~mclk;
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic check(string what, logic [6:0] seen, logic [6:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge mclk);
    #1;
    s = 1'b0;
  endtask : pulse
  // Wait for reset end, then compare holdoff and gap
  task automatic settle(logic [6:0] exp);
    int i;
    i = 0;
    while (bus_reset_done !== 1'b1 && i < 40) begin
      @(posedge mclk);
      #1;
      i++;
    end
    check("done", {6'h00, bus_reset_done}, 7'h01);
    check("fields", {root_holdoff_flag, gap_setting}, exp);
  endtask : settle
  task automatic t_user();
    pulse(user_reset_req);
    check("busy", {6'h00, user_busy}, 7'h01);
    settle(7'h3f);
    check("idle", {6'h00, user_busy}, 7'h00);
    $display("user test end");
  endtask : t_user
  task automatic t_send();
    cfg_holdoff = 1'b1;
    cfg_gap = 6'h05;
    // New node reset lands before the confirming write
    ext_bus_reset = 1'b1;
    pulse(cfg_send);
    ext_bus_reset = 1'b0;
    check("sent", {root_holdoff_flag, gap_setting}, 7'h45);
    check("active", {6'h00, bus_reset_active}, 7'h01);
    settle(7'h45);
    pulse(ext_bus_reset);
    settle(7'h7f);
    $display("send test end");
  endtask : t_send
  task automatic t_recv();
    cfg_holdoff = 1'b0;
    cfg_gap = 6'h0a;
    pulse(cfg_recv);
    check("recv", {root_holdoff_flag, gap_setting}, 7'h0a);
    pulse(ext_bus_reset);
    settle(7'h0a);
    pulse(ext_bus_reset);
    settle(7'h3f);
    $display("recv test end");
  endtask : t_recv
  initial begin
    repeat (3) @(posedge mclk);
    #1;
    reset = 1'b0;
    t_user();
    t_send();
    t_recv();
    test_done();
  end
endmodule : tb
